// >>> hdl/afr_ctrl_regs.v
// Control register bank with serial write/readback port for an 8-channel receive converter
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: Any reset clears every converter control register to zero.
// RULE2: Controller writes zero into undefined bit positions.
// RULE3: Demodulator logic restores its own defaults, some ones, on demodulator reset.
// RULE4: Clearing demodulator disable resets demodulator; controller then reprograms it.
// RULE5: Writing one to soft reset resets everything; the bit self-clears.
// RULE6: Register zero is write only; readback returns zero for it.
// RULE7: Readback enable selects read mode and drives data on serial output.
// RULE8: Read or write mode persists across transactions until changed.
// RULE9: Full power down; demodulator is reset on exit and must be reloaded.
// RULE10: Eight bits power down converter channels, low bit is channel 1.
// RULE11: Partial power down bit selects partial power-down state.
// RULE12: External reference needs register 1 bit and register 3 bit both set.
// RULE13: Double-rate bit merges two channels onto one output pair.
// RULE14: Eight bits power down output pairs, low bit is channel 1.
// RULE15: Averaging bit averages channel pairs for better noise.
// RULE16: Low-latency bit bypasses digital processing.
// RULE17: 24-bit words, 8 address then 16 data, load on every 24th edge.
// RULE18: Serial output stays undriven unless readback is enabled.
// RULE19: Hardware reset pulse also initialises all registers.
// RULE20: Power-down bits affect only circuits, never stored register contents.
// RULE21: Reserved bits of register 2 are stored but drive nothing.
`include "afr_regs_consts.vh"

module afr_ctrl_regs (
    // Clock and reset
    input wire clock,
    input wire nrst,
    input wire hwReset,
    // Serial port, already synchronous to clock
    input wire serEnableN,
    input wire serClock,
    input wire serData,
    output wire serialReadbackOutput,
    output wire serialReadbackOeN,
    // Reference select bit held in register 3 of another bank
    input wire extRefReg3,
    // Power and reference controls
    output wire fullPowerDown,
    output wire outputDisable,
    output wire [7:0] converterChannelPowerDown,
    output wire partialPowerDown,
    output wire lowFreqSuppress,
    output wire externalReferenceSelect,
    output wire doubleRatePacking,
    output wire singleEndedClock,
    // Output pair and processing controls
    output wire [7:0] outputPairPowerDown,
    output wire averagingEnable,
    output wire lowLatency,
    output wire [2:0] testPatternMode,
    // Demodulator control
    output wire demodDisable,
    output wire demodReset,
    // Register view
    output wire readbackEnable
);

    // Readback mux; register 0 and unmapped addresses return zero
    function [15:0] regRead;
        input [7:0] addr;
        input [15:0] r1;
        input [15:0] r2;
        input dd;
        begin
            case (addr)
                `AFR_ADDR_POWER_REF_OUT: regRead = r1;
                `AFR_ADDR_OUT_PROC: regRead = r2;
                `AFR_ADDR_DEMOD_DISABLE: regRead = {15'h0000, dd};
                default: regRead = 16'h0000; // RULE6
            endcase
        end
    endfunction

    reg [15:0] cfg1_reg;
    reg [15:0] cfg1_next;
    reg [15:0] cfg2_reg;
    reg [15:0] cfg2_next;
    reg demodDisable_reg;
    reg demodDisable_next;
    reg readbackEnable_reg;
    reg readbackEnable_next;
    reg softReset_reg;
    reg softReset_next;
    reg [4:0] bitCount_reg;
    reg [4:0] bitCount_next;
    reg [22:0] shift_reg;
    reg [22:0] shift_next;
    reg serClockPrev_reg;
    reg [15:0] readShift_reg;
    reg [15:0] readShift_next;
    reg serOut_reg;
    reg serOut_next;
    reg serOeN_reg;
    reg extRef_reg;
    reg demodReset_reg;
    reg demodReset_next;

    wire resetAll;
    wire sclkRise;
    wire sclkFall;
    wire [23:0] wordIn;
    wire [7:0] wordAddr;
    wire [15:0] wordData;
    wire [7:0] addrIn;

    // Soft reset acts one cycle after the word lands, so it covers the whole bank
    assign resetAll = !nrst || hwReset || softReset_reg; // RULE19 RULE5
    assign sclkRise = serClock && !serClockPrev_reg;
    assign sclkFall = !serClock && serClockPrev_reg;
    assign wordIn = {shift_reg, serData};
    assign wordAddr = wordIn[23:16]; // RULE17
    assign wordData = wordIn[15:0];
    assign addrIn = {shift_reg[6:0], serData};

    always @* begin
        cfg1_next = cfg1_reg;
        cfg2_next = cfg2_reg;
        demodDisable_next = demodDisable_reg;
        readbackEnable_next = readbackEnable_reg; // RULE8
        softReset_next = 1'b0;
        bitCount_next = bitCount_reg;
        shift_next = shift_reg;
        readShift_next = readShift_reg;
        serOut_next = serOut_reg;
        demodReset_next = 1'b0;
        if (serEnableN) begin
            bitCount_next = 5'h00;
            serOut_next = 1'b0;
        end else begin
            if (sclkRise) begin
                shift_next = wordIn[22:0];
                if (bitCount_reg == `AFR_WORD_LAST) begin
                    bitCount_next = 5'h00; // RULE17
                end else begin
                    bitCount_next = bitCount_reg + 5'h01;
                end
                if (readbackEnable_reg && bitCount_reg == `AFR_ADDR_PHASE_LAST) begin
                    readShift_next = regRead(addrIn, cfg1_reg, cfg2_reg, demodDisable_reg); // RULE7
                end
                if (bitCount_reg == `AFR_WORD_LAST) begin
                    // Register 0 stays writable in read mode so readback can be turned off
                    if (wordAddr == `AFR_ADDR_RESET_READBACK) begin
                        readbackEnable_next = wordData[`AFR_READBACK_EN_BIT]; // RULE7
                        softReset_next = wordData[`AFR_SOFT_RESET_BIT]; // RULE5
                    end else if (!readbackEnable_reg) begin
                        case (wordAddr)
                            `AFR_ADDR_POWER_REF_OUT: begin
                                cfg1_next = wordData;
                                if (cfg1_reg[`AFR_FULL_PDN_BIT] && !wordData[`AFR_FULL_PDN_BIT]) begin
                                    demodReset_next = 1'b1; // RULE9
                                end
                            end
                            `AFR_ADDR_OUT_PROC: begin
                                cfg2_next = wordData; // RULE21
                            end
                            `AFR_ADDR_DEMOD_DISABLE: begin
                                demodDisable_next = wordData[`AFR_DEMOD_DISABLE_BIT];
                                if (demodDisable_reg && !wordData[`AFR_DEMOD_DISABLE_BIT]) begin
                                    demodReset_next = 1'b1; // RULE4
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            if (sclkFall) begin
                serOut_next = readShift_reg[15];
                readShift_next = {readShift_reg[14:0], 1'b0};
            end
        end
    end

    always @(posedge clock) begin
        serClockPrev_reg <= serClock;
        if (resetAll) begin
            cfg1_reg <= `AFR_RESET_VALUE; // RULE1
            cfg2_reg <= `AFR_RESET_VALUE; // RULE1
            demodDisable_reg <= `AFR_DEMOD_DISABLE_RESET;
            readbackEnable_reg <= 1'b0;
            softReset_reg <= 1'b0;
            bitCount_reg <= 5'h00;
            shift_reg <= 23'h00_0000;
            readShift_reg <= 16'h0000;
            serOut_reg <= 1'b0;
            serOeN_reg <= 1'b1;
            extRef_reg <= 1'b0;
            // Demodulator reloads its own defaults, some of which are ones
            demodReset_reg <= 1'b1; // RULE3
        end else begin
            cfg1_reg <= cfg1_next; // RULE20
            cfg2_reg <= cfg2_next;
            demodDisable_reg <= demodDisable_next;
            readbackEnable_reg <= readbackEnable_next;
            softReset_reg <= softReset_next;
            bitCount_reg <= bitCount_next;
            shift_reg <= shift_next;
            readShift_reg <= readShift_next;
            serOut_reg <= serOut_next;
            serOeN_reg <= !readbackEnable_next; // RULE18
            extRef_reg <= cfg1_next[`AFR_EXTERNAL_REFERENCE_SELECT_BIT] && extRefReg3; // RULE12
            demodReset_reg <= demodReset_next;
        end
    end

    assign serialReadbackOutput = serOut_reg;
    assign serialReadbackOeN = serOeN_reg;
    assign fullPowerDown = cfg1_reg[`AFR_FULL_PDN_BIT]; // RULE9
    assign outputDisable = cfg1_reg[`AFR_OUT_DISABLE_BIT];
    assign converterChannelPowerDown = cfg1_reg[`AFR_CH_PDN_MSB:`AFR_CH_PDN_LSB]; // RULE10
    assign partialPowerDown = cfg1_reg[`AFR_PARTIAL_POWER_DOWN_BIT]; // RULE11
    assign lowFreqSuppress = cfg1_reg[`AFR_LF_SUPPRESS_BIT];
    assign externalReferenceSelect = extRef_reg;
    assign doubleRatePacking = cfg1_reg[`AFR_DOUBLE_RATE_BIT]; // RULE13
    assign singleEndedClock = cfg1_reg[`AFR_SE_CLOCK_BIT];
    assign outputPairPowerDown = cfg2_reg[`AFR_PAIR_PDN_MSB:`AFR_PAIR_PDN_LSB]; // RULE14
    assign averagingEnable = cfg2_reg[`AFR_AVERAGE_BIT]; // RULE15
    assign lowLatency = cfg2_reg[`AFR_LOW_LATENCY_BIT]; // RULE16
    assign testPatternMode = cfg2_reg[15:13];
    assign demodDisable = demodDisable_reg;
    assign demodReset = demodReset_reg;
    assign readbackEnable = readbackEnable_reg;

endmodule // afr_ctrl_regs
`default_nettype wire

// >>> hdl/afr_regs_consts.vh
// Constants for the converter front-end control register bank
`ifndef AFR_REGS_CONSTS_VH
`define AFR_REGS_CONSTS_VH

// Serial word layout
`define AFR_WORD_BITS 24
`define AFR_ADDR_BITS 8
`define AFR_DATA_BITS 16
`define AFR_ADDR_PHASE_LAST 5'h07
`define AFR_WORD_LAST 5'h17

// Register addresses
`define AFR_ADDR_RESET_READBACK 8'h00
`define AFR_ADDR_POWER_REF_OUT 8'h01
`define AFR_ADDR_OUT_PROC 8'h02
`define AFR_ADDR_DEMOD_DISABLE 8'h16

// Reset values
`define AFR_RESET_VALUE 16'h0000
`define AFR_DEMOD_DISABLE_RESET 1'b0

// Register 0 fields
`define AFR_SOFT_RESET_BIT 0
`define AFR_READBACK_EN_BIT 1

// Register 1 fields
`define AFR_FULL_PDN_BIT 0
`define AFR_OUT_DISABLE_BIT 1
`define AFR_CH_PDN_LSB 2
`define AFR_CH_PDN_MSB 9
`define AFR_PARTIAL_POWER_DOWN_BIT 10
`define AFR_LF_SUPPRESS_BIT 11
`define AFR_EXTERNAL_REFERENCE_SELECT_BIT 13
`define AFR_DOUBLE_RATE_BIT 14
`define AFR_SE_CLOCK_BIT 15

// Register 2 fields
`define AFR_RSVD_LSB 0
`define AFR_RSVD_MSB 2
`define AFR_PAIR_PDN_LSB 3
`define AFR_PAIR_PDN_MSB 10
`define AFR_AVERAGE_BIT 11
`define AFR_LOW_LATENCY_BIT 12

// Demodulator disable field
`define AFR_DEMOD_DISABLE_BIT 0

`endif

// >>> dv/afr_ser_host.sv
// Serial controller model for the register bank's write and readback port
`timescale 1ns/1ps
`default_nettype none
module afr_ser_host (
    // Clock
    input wire logic clock,
    // Serial port
    output logic serEnableN,
    output logic serClock,
    output logic serData,
    input wire logic serialReadbackOutput
);
    initial begin
        serEnableN = 1'b1;
        serClock = 1'b0;
        serData = 1'b0;
    end
    // Each serial half period spans two clocks so every edge is sampled
    task automatic xfer(input logic [23:0] w, output logic [15:0] rd);
        rd = 16'h0000;
        @(posedge clock);
        #1 serEnableN = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            serClock = 1'b0;
            serData = w[i];
            repeat (2) @(posedge clock);
            #1;
            if (i < 16) rd = {rd[14:0], serialReadbackOutput};
            serClock = 1'b1;
            repeat (2) @(posedge clock);
            #1;
        end
        // Idle: serial clock stands still, data falls to its pull-down level
        serClock = 1'b0;
        serData = 1'b0;
        repeat (3) @(posedge clock);
        #1 serEnableN = 1'b1;
        repeat (2) @(posedge clock);
        #1;
    endtask
endmodule // afr_ser_host
`default_nettype wire

// >>> dv/afr_ctrl_regs_assertions.sv
// Port-level checker for the control register bank
`timescale 1ns/1ps
`default_nettype none
module afr_ctrl_regs_assertions (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    input wire logic hwReset,
    // Serial port
    input wire logic serEnableN,
    input wire logic serialReadbackOutput,
    input wire logic serialReadbackOeN,
    input wire logic extRefReg3,
    // Controls
    input wire logic fullPowerDown,
    input wire logic externalReferenceSelect,
    input wire logic [7:0] converterChannelPowerDown,
    input wire logic [7:0] outputPairPowerDown,
    input wire logic lowLatency,
    input wire logic demodDisable,
    input wire logic demodReset,
    input wire logic readbackEnable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    AST_HW_RESET: assert property (hwReset |=> !fullPowerDown && converterChannelPowerDown == 0
        && outputPairPowerDown == 0 && !readbackEnable && serialReadbackOeN && demodReset)
        else $error("hardware reset left state");
    AST_OE_OFF: assert property (!readbackEnable && !$past(readbackEnable) |-> serialReadbackOeN)
        else $error("readback driver on outside read mode");
    AST_OUT_IDLE: assert property (serialReadbackOeN |-> !serialReadbackOutput)
        else $error("readback data while undriven");
    AST_DEMOD_RST: assert property ($fell(demodDisable) |-> ##[0:2] demodReset)
        else $error("no demodulator reset after disable cleared");
    AST_PDN_EXIT: assert property ($fell(fullPowerDown) |-> ##[0:2] demodReset)
        else $error("no demodulator reset after power-down exit");
    AST_QUIET: assert property (serEnableN && $past(serEnableN) && $past(nrst) && !$past(hwReset)
        |-> $stable(converterChannelPowerDown) && $stable(outputPairPowerDown) && $stable(lowLatency))
        else $error("control changed with no serial word");
    AST_EXTERNAL_REFERENCE_SELECT: assert property (externalReferenceSelect |-> $past(extRefReg3))
        else $error("external reference without second select bit");
    AST_MODE_HOLD: assert property ($rose(readbackEnable) |-> !$past(serEnableN))
        else $error("read mode entered without a write");
    COV_READ: cover property ($rose(readbackEnable));
    COV_DEMOD: cover property ($fell(demodDisable));
    COV_HW: cover property (hwReset);
endmodule // afr_ctrl_regs_assertions
bind afr_ctrl_regs afr_ctrl_regs_assertions afr_ctrl_regs_assertions_i (.clock, .nrst, .hwReset,
    .serEnableN, .serialReadbackOutput, .serialReadbackOeN, .extRefReg3, .fullPowerDown,
    .externalReferenceSelect, .converterChannelPowerDown, .outputPairPowerDown, .lowLatency,
    .demodDisable, .demodReset, .readbackEnable);
`default_nettype wire

// >>> dv/tb_afr_ctrl_regs.sv
// Self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_afr_ctrl_regs;
    logic clock, nrst, hwReset, extRefReg3;
    logic [15:0] rd;
    int error_cnt, n_checks, cyc;
    wire serEnableN, serClock, serData, serialReadbackOutput, serialReadbackOeN;
    wire fullPowerDown, outputDisable, partialPowerDown, lowFreqSuppress, externalReferenceSelect;
    wire doubleRatePacking, singleEndedClock, averagingEnable, lowLatency;
    wire demodDisable, demodReset, readbackEnable;
    wire [7:0] converterChannelPowerDown, outputPairPowerDown;
    wire [2:0] testPatternMode;
    // Outputs regrouped into their register layouts
    wire [15:0] r1View = {singleEndedClock, doubleRatePacking, externalReferenceSelect, 1'b0,
        lowFreqSuppress, partialPowerDown, converterChannelPowerDown, outputDisable, fullPowerDown};
    wire [15:0] r2View = {testPatternMode, lowLatency, averagingEnable, outputPairPowerDown, 3'b000};
    afr_ctrl_regs afr_ctrl_regs_i (.clock, .nrst, .hwReset, .serEnableN, .serClock, .serData,
        .serialReadbackOutput, .serialReadbackOeN, .extRefReg3, .fullPowerDown, .outputDisable,
        .converterChannelPowerDown, .partialPowerDown, .lowFreqSuppress, .externalReferenceSelect,
        .doubleRatePacking, .singleEndedClock, .outputPairPowerDown, .averagingEnable, .lowLatency,
        .testPatternMode, .demodDisable, .demodReset, .readbackEnable);
    afr_ser_host afr_ser_host_i (.clock, .serEnableN, .serClock, .serData, .serialReadbackOutput);
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task close_out;
        $display("Checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task t_fields;
        afr_ser_host_i.xfer(24'h01_6416, rd);
        afr_ser_host_i.xfer(24'h02_1A28, rd);
        chk("reg1", 16'h6416, r1View);
        chk("reg2", 16'h1A28, r2View);
        // Second select bit withdrawn: external reference must drop
        extRefReg3 = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk("extRefOff", 16'h0000, {15'h0, externalReferenceSelect});
        extRefReg3 = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk("extRefOn", 16'h0001, {15'h0, externalReferenceSelect});
    endtask
    task t_readback;
        afr_ser_host_i.xfer(24'h00_0002, rd);
        chk("oeN", 16'h0000, {15'h0, serialReadbackOeN});
        afr_ser_host_i.xfer(24'h01_0000, rd);
        chk("rd1", 16'h6416, rd);
        afr_ser_host_i.xfer(24'h02_FFFF, rd);
        chk("rd2", 16'h1A28, rd);
        chk("reg2", 16'h1A28, r2View);
        afr_ser_host_i.xfer(24'h00_0000, rd);
        chk("rd0", 16'h0000, rd);
        chk("oeN", 16'h0001, {15'h0, serialReadbackOeN});
    endtask
    task t_demod;
        afr_ser_host_i.xfer(24'h01_6417, rd);
        chk("fullPdn", 16'h0001, {15'h0, fullPowerDown});
        afr_ser_host_i.xfer(24'h16_0001, rd);
        chk("demodOn", 16'h0001, {15'h0, demodDisable});
        afr_ser_host_i.xfer(24'h16_0000, rd);
        chk("demodOff", 16'h0000, {15'h0, demodDisable});
        afr_ser_host_i.xfer(24'h01_6416, rd);
        chk("reg1", 16'h6416, r1View);
    endtask
    task t_resets;
        afr_ser_host_i.xfer(24'h01_8802, rd);
        chk("reg1b", 16'h8802, r1View);
        afr_ser_host_i.xfer(24'h02_E000, rd);
        chk("reg2b", 16'hE000, r2View);
        afr_ser_host_i.xfer(24'h00_0001, rd);
        chk("softR1", 16'h0000, r1View);
        chk("softR2", 16'h0000, r2View);
        afr_ser_host_i.xfer(24'h02_1A28, rd);
        hwReset = 1'b1;
        @(posedge clock);
        #1 hwReset = 1'b0;
        @(posedge clock);
        #1;
        chk("hwR2", 16'h0000, r2View);
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Whole run needs about 1500 cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            close_out;
        end
    end
    initial begin
        nrst = 1'b0;
        hwReset = 1'b0;
        extRefReg3 = 1'b1;
        repeat (2) @(posedge clock);
        #1 nrst = 1'b1;
        chk("reg1", 16'h0000, r1View);
        chk("reg2", 16'h0000, r2View);
        t_fields;
        t_readback;
        t_demod;
        t_resets;
        close_out;
    end
endmodule // tb_afr_ctrl_regs
`default_nettype wire
